// ==== rtl/ffc_pkg.sv ====
package ffc_pkg;
	// clock rate of the supervising logic
	localparam int unsigned CLK_MHZ = 50;

	// register offsets on the plain register port
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_INT_EN = 8'h04;
	localparam logic [7:0] REG_INT_CLR = 8'h08;
	localparam logic [7:0] REG_OSC_CTRL = 8'h0c;
	localparam logic [7:0] REG_CFG_BASE = 8'h10;

	// configuration space and flash image
	localparam int CFG_WORDS = 4;
	localparam logic [23:0] CFG_SPACE_BASE = 24'h300000;
	localparam logic [23:0] CFG_SPACE_BYTES = 24'h000008;
	localparam logic [21:0] FLASH_CFG_ADDR = 22'h3ffff8;
	localparam logic [15:0] CFG_UNPROG = 16'hffff;
	localparam logic [15:0] CFG_MASK_HI_NOP = 16'h0fff;
	localparam logic [15:0] CFG_MASK_FULL = 16'hffff;
	localparam int MODE_WORD = 1;
	localparam int MODE_LSB = 8;

	// primary oscillator modes in the second high config word
	localparam logic [1:0] OSC_EXT = 2'h0;
	localparam logic [1:0] OSC_INTERNAL_RC_CLOCK = 2'h1;
	localparam logic [1:0] OSC_HS = 2'h2;
	localparam logic [1:0] OSC_CRYSTAL_WITH_MULTIPLIER_MODE = 2'h3;
	localparam logic [1:0] MODE_RESET = CFG_UNPROG[MODE_LSB +: 2];

	// oscillator control register layout
	localparam int OCR_SEL_LSB = 0;
	localparam int OCR_FAIL_BIT = 2;
	localparam int OCR_READY_BIT = 3;
	localparam logic [1:0] SEL_PRIMARY = 2'h0;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;
	localparam logic [1:0] SEL_INTERNAL_RC_CLOCK = 2'h2;
	localparam logic [1:0] OCR_SEL_RESET = 2'h0;

	// interrupt status bits
	localparam int INT_W = 3;
	localparam int INT_FAIL = 0;
	localparam int INT_READY = 1;
	localparam int INT_LOADED = 2;

	// timing: start-up timer counts primary periods, others are times
	localparam logic [15:0] OST_PERIODS = 16'h0400;
	localparam int unsigned PLL_LOCK_NS = 2000;
	localparam logic [7:0] PLL_LOCK_CYC = 8'((PLL_LOCK_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned MON_WINDOW_NS = 640;
	localparam logic [7:0] MON_LIMIT = 8'((MON_WINDOW_NS * CLK_MHZ) / 1000);

	typedef enum logic [2:0] {ST_LOAD, ST_START, ST_PLL, ST_PRIM, ST_FAILSAFE, ST_PM, ST_SLEEP} ffc_state_e;

	// implemented bits of each config word
	function automatic logic [15:0] cfg_mask(input logic [1:0] idx);
		cfg_mask = (idx == 2'h3) ? CFG_MASK_FULL : CFG_MASK_HI_NOP;
	endfunction
endpackage

// ==== rtl/ffc_cfg_loader.sv ====
`timescale 1ns/1ps
module ffc_cfg_loader
	import ffc_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [15:0] flash_data_i,
	output logic [21:0] flash_addr_o,
	output logic flash_rd_o,
	output logic [15:0] word_o,
	output logic [1:0] idx_o,
	output logic word_vld_o,
	output logic done_o
);
	logic [2:0] cnt;
	logic wait_q;

	// one flash read at a time, data taken the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt <= 3'h0;
			wait_q <= 1'b0;
			flash_rd_o <= 1'b0;
			flash_addr_o <= FLASH_CFG_ADDR;
			word_vld_o <= 1'b0;
			word_o <= CFG_UNPROG;
			idx_o <= 2'h0;
			done_o <= 1'b0;
		end else begin
			wait_q <= flash_rd_o;
			word_vld_o <= 1'b0;
			flash_rd_o <= 1'b0;
			if (wait_q) begin
				word_o <= flash_data_i;
				idx_o <= cnt[1:0];
				word_vld_o <= 1'b1;
				cnt <= cnt + 3'h1;
				done_o <= (cnt == 3'h3);
			end else if (!done_o && !flash_rd_o) begin
				flash_rd_o <= 1'b1;
				flash_addr_o <= FLASH_CFG_ADDR + {18'h0, cnt[1:0], 2'h0} / 22'h2;
			end
		end
	end
endmodule

// ==== rtl/ffc_top.sv ====
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
// What this block does
// - config bits read 0 when programmed, 1 when unprogrammed.
// - config space readable starting at address 300000h.
// - after every reset copy four flash words, lowest word first.
// - each config bit writable once per power cycle; mode is taken from flash on every reset.
// - monitor watches the clock and falls back to internal RC on failure.
// - fail-safe ends only by reset, power-managed mode entry or sleep.
// - reset starts configured primary source with its start-up and PLL delays.
// - internal RC clocks until primary ready, then switch and set ready flag.
// - monitoring resumes once the primary clock is switched in.
// - primary never ready: stay on internal RC, control register keeps reset value.
// - power-managed entry selects source from control register and monitors it unless internal RC is selected.
// - failure in power-managed mode runs on internal RC, never switches back.
// - with failure interrupt disabled, an interrupt in idle wakes CPU on RC.
// - monitoring active after reset or sleep; immediate in external and RC modes.
// - crystal modes run on internal RC, unmonitored, until timers expire.
// - in crystal modes a primary that never starts raises no failure flag.
// - power-managed mode chosen during start-up disables the primary clock unless primary is selected.
module ffc_top
	import ffc_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic por_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [23:0] cfg_addr_i,
	input wire logic cfg_re_i,
	output logic [7:0] cfg_rdata_o,
	output logic [21:0] flash_addr_o,
	output logic flash_rd_o,
	input wire logic [15:0] flash_data_i,
	input wire logic prim_act_i,
	input wire logic sec_act_i,
	input wire logic pm_enter_i,
	input wire logic sleep_i,
	input wire logic wake_i,
	input wire logic idle_i,
	input wire logic ext_int_i,
	output logic prim_en_o,
	output logic pll_en_o,
	output logic [1:0] clk_sel_o,
	output logic mon_active_o,
	output logic cpu_wake_o,
	output logic cfg_ready_o,
	output logic irq_o
);
	ffc_state_e state, next_state;
	logic [1:0] mode;
	logic [15:0] cfg [CFG_WORDS];
	logic [15:0] lock [CFG_WORDS];
	logic [1:0] ocr_sel, next_sel;
	logic ready, failsafe;
	logic [INT_W-1:0] int_status, int_en, next_status, next_en, int_ev, int_clr;
	logic [15:0] ost_cnt;
	logic [7:0] pll_cnt, mon_cnt;
	logic mon_on, mon_act, mon_fail;
	logic ld_done_q, load_evt, ready_rise;
	logic [15:0] ld_word;
	logic [1:0] ld_idx;
	logic ld_vld;
	logic wr_cfg;
	logic [1:0] wr_idx;
	logic [23:0] cfg_off;

	// source the device clock mux takes in a given state
	function automatic logic [1:0] clk_for(input ffc_state_e s, input logic [1:0] sel);
		case (s)
			ST_PRIM: clk_for = SEL_PRIMARY;
			ST_PM: clk_for = sel;
			default: clk_for = SEL_INTERNAL_RC_CLOCK;
		endcase
	endfunction

	// whether the primary oscillator runs in a given state
	function automatic logic prim_for(input ffc_state_e s, input logic [1:0] sel);
		case (s)
			ST_START, ST_PLL, ST_PRIM: prim_for = 1'b1;
			ST_PM: prim_for = (sel == SEL_PRIMARY);
			default: prim_for = 1'b0;
		endcase
	endfunction

	// whether the monitor supervises in a given state
	function automatic logic mon_for(input ffc_state_e s, input logic [1:0] sel);
		mon_for = (s == ST_PRIM) || (s == ST_PM && sel != SEL_INTERNAL_RC_CLOCK);
	endfunction

	// start-up path after reset or wake, by oscillator mode
	function automatic ffc_state_e after_start(input logic [1:0] m);
		after_start = (m == OSC_HS || m == OSC_CRYSTAL_WITH_MULTIPLIER_MODE) ? ST_START : ST_PRIM;
	endfunction

	ffc_cfg_loader u_loader (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.flash_data_i(flash_data_i),
		.flash_addr_o(flash_addr_o),
		.flash_rd_o(flash_rd_o),
		.word_o(ld_word),
		.idx_o(ld_idx),
		.word_vld_o(ld_vld),
		.done_o(cfg_ready_o)
	);

	// register port decode
	assign wr_cfg = reg_we_i && reg_addr_i[7:4] == REG_CFG_BASE[7:4] && reg_addr_i[1:0] == 2'h0;
	assign wr_idx = reg_addr_i[3:2];
	assign next_sel = (reg_we_i && reg_addr_i == REG_OSC_CTRL)
		? (reg_wdata_i[OCR_SEL_LSB + 1] ? SEL_INTERNAL_RC_CLOCK : reg_wdata_i[OCR_SEL_LSB +: 2]) : ocr_sel;
	assign next_en = (reg_we_i && reg_addr_i == REG_INT_EN) ? reg_wdata_i[INT_W-1:0] : int_en;
	assign int_clr = (reg_we_i && reg_addr_i == REG_INT_CLR) ? reg_wdata_i[INT_W-1:0] : '0;

	// event strobes
	assign load_evt = cfg_ready_o && !ld_done_q;
	assign ready_rise = next_state == ST_PRIM && state != ST_PRIM;

	// monitor sees the clock that is actually selected
	assign mon_on = mon_for(state, ocr_sel);
	assign mon_act = (state == ST_PM && ocr_sel == SEL_SECONDARY) ? sec_act_i : prim_act_i;
	assign mon_fail = mon_on && !mon_act && mon_cnt == MON_LIMIT;

	// clock supervision sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_LOAD: if (load_evt) next_state = after_start(mode);
			ST_START: begin
				if (pm_enter_i) next_state = ST_PM;
				else if (sleep_i) next_state = ST_SLEEP;
				else if (ost_cnt == OST_PERIODS) next_state = (mode == OSC_CRYSTAL_WITH_MULTIPLIER_MODE) ? ST_PLL : ST_PRIM;
			end
			ST_PLL: begin
				if (pm_enter_i) next_state = ST_PM;
				else if (sleep_i) next_state = ST_SLEEP;
				else if (pll_cnt == PLL_LOCK_CYC) next_state = ST_PRIM;
			end
			ST_PRIM, ST_PM: begin
				if (mon_fail) next_state = ST_FAILSAFE;
				else if (pm_enter_i) next_state = ST_PM;
				else if (sleep_i) next_state = ST_SLEEP;
			end
			ST_FAILSAFE: begin
				if (pm_enter_i) next_state = ST_PM;
				else if (sleep_i) next_state = ST_SLEEP;
			end
			ST_SLEEP: if (wake_i) next_state = after_start(mode);
			default: next_state = ST_LOAD;
		endcase
	end

	// state and clock steering outputs
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state <= ST_LOAD;
			clk_sel_o <= SEL_INTERNAL_RC_CLOCK;
			prim_en_o <= 1'b0;
			pll_en_o <= 1'b0;
			mon_active_o <= 1'b0;
			ld_done_q <= 1'b0;
		end else begin
			state <= next_state;
			clk_sel_o <= clk_for(next_state, next_sel);
			prim_en_o <= prim_for(next_state, next_sel);
			pll_en_o <= prim_for(next_state, next_sel) && mode == OSC_CRYSTAL_WITH_MULTIPLIER_MODE;
			mon_active_o <= mon_for(next_state, next_sel);
			ld_done_q <= cfg_ready_o;
		end
	end

	// start-up timer counts primary periods, lock timer counts cycles
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ost_cnt <= 16'h0;
			pll_cnt <= 8'h0;
		end else begin
			ost_cnt <= (state != ST_START) ? 16'h0 : ost_cnt + {15'h0, prim_act_i};
			pll_cnt <= (state != ST_PLL) ? 8'h0 : pll_cnt + 8'h1;
		end
	end

	// missing-activity window counter
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mon_cnt <= 8'h0;
		end else if (!mon_on || mon_act) begin
			mon_cnt <= 8'h0;
		end else if (mon_cnt != MON_LIMIT) begin
			mon_cnt <= mon_cnt + 8'h1;
		end
	end

	// oscillator control register: ready and fail-safe flags
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ocr_sel <= OCR_SEL_RESET;
			ready <= 1'b0;
			failsafe <= 1'b0;
		end else begin
			ocr_sel <= next_sel;
			if (ready_rise) ready <= 1'b1;
			else if (next_state == ST_START || next_state == ST_FAILSAFE || next_state == ST_SLEEP) ready <= 1'b0;
			failsafe <= next_state == ST_FAILSAFE;
		end
	end

	// latched oscillator mode only from flash, so register writes never change it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mode <= MODE_RESET;
		end else if (ld_vld && ld_idx == 2'(MODE_WORD)) begin
			mode <= ld_word[MODE_LSB +: 2];
		end
	end

	// volatile config words: reload on reset, software writes once per bit
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < CFG_WORDS; i++) cfg[i] <= CFG_UNPROG;
		end else if (ld_vld) begin
			cfg[ld_idx] <= ld_word | ~cfg_mask(ld_idx);
		end else if (wr_cfg) begin
			cfg[wr_idx] <= (cfg[wr_idx] & lock[wr_idx]) | (reg_wdata_i[15:0] & ~lock[wr_idx])
				| ~cfg_mask(wr_idx);
		end
	end

	// write-once locks survive ordinary resets, cleared by power-on only
	always_ff @(posedge clk_i) begin
		if (!por_n_i) begin
			for (int i = 0; i < CFG_WORDS; i++) lock[i] <= 16'h0;
		end else if (wr_cfg && !ld_vld) begin
			lock[wr_idx] <= lock[wr_idx] | cfg_mask(wr_idx);
		end
	end

	// sticky interrupt status, set wins over clear
	assign int_ev[INT_FAIL] = mon_fail;
	assign int_ev[INT_READY] = ready_rise;
	assign int_ev[INT_LOADED] = load_evt;
	assign next_status = (int_status & ~int_clr) | int_ev;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			int_status <= '0;
			int_en <= '0;
			irq_o <= 1'b0;
		end else begin
			int_status <= next_status;
			int_en <= next_en;
			irq_o <= |(next_status & next_en);
		end
	end

	// wake on other interrupt while idle in fail-safe with fail interrupt off
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cpu_wake_o <= 1'b0;
		end else begin
			cpu_wake_o <= state == ST_FAILSAFE && !int_en[INT_FAIL] && idle_i && ext_int_i;
		end
	end

	// register read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 32'h0;
		end else begin
			reg_rdata_o <= 32'h0;
			if (reg_re_i) begin
				case (reg_addr_i)
					REG_STATUS: reg_rdata_o <= {29'h0, int_status};
					REG_INT_EN: reg_rdata_o <= {29'h0, int_en};
					REG_OSC_CTRL: reg_rdata_o <= {28'h0, ready, failsafe, ocr_sel};
					default: begin
						if (reg_addr_i[7:4] == REG_CFG_BASE[7:4] && reg_addr_i[1:0] == 2'h0)
							reg_rdata_o <= {16'h0, cfg[reg_addr_i[3:2]]};
					end
				endcase
			end
		end
	end

	// config space byte reads
	assign cfg_off = cfg_addr_i - CFG_SPACE_BASE;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cfg_rdata_o <= 8'h0;
		end else if (cfg_re_i && cfg_off < CFG_SPACE_BYTES) begin
			cfg_rdata_o <= cfg_off[0] ? cfg[cfg_off[2:1]][15:8] : cfg[cfg_off[2:1]][7:0];
		end else begin
			cfg_rdata_o <= 8'h0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_load_to_start;
		state == ST_LOAD ##1 state == ST_START;
	endsequence

	sequence s_fail_seen;
		mon_fail ##1 state == ST_FAILSAFE;
	endsequence

	fail_switch_a: assert property (mon_fail |=> state == ST_FAILSAFE && clk_sel_o == SEL_INTERNAL_RC_CLOCK && !prim_en_o)
		else $error("failure did not switch to internal rc");
	failsafe_hold_a: assert property (state == ST_FAILSAFE && !pm_enter_i && !sleep_i |=> state == ST_FAILSAFE)
		else $error("fail-safe left without cause");
	start_mode_a: assert property (s_load_to_start |-> (mode == OSC_HS || mode == OSC_CRYSTAL_WITH_MULTIPLIER_MODE) && prim_en_o)
		else $error("start-up entered for wrong mode");
	ready_switch_a: assert property ($rose(ready) |-> state == ST_PRIM && clk_sel_o == SEL_PRIMARY)
		else $error("ready flag set off the primary clock");
	startup_rc_a: assert property (state == ST_START || state == ST_PLL |-> clk_sel_o == SEL_INTERNAL_RC_CLOCK
		&& !mon_active_o && !ready)
		else $error("start-up not on internal rc");
	no_false_fail_a: assert property (state == ST_START || state == ST_PLL || state == ST_LOAD
		|=> !$rose(int_status[INT_FAIL]))
		else $error("failure raised during start-up");
	pm_prim_off_a: assert property (state == ST_START && pm_enter_i && next_sel != SEL_PRIMARY |=> !prim_en_o)
		else $error("primary left running after mode change");
	pm_select_a: assert property (state == ST_PM |-> clk_sel_o == ocr_sel)
		else $error("power-managed source not from control");
	no_return_a: assert property (s_fail_seen |-> clk_sel_o == SEL_INTERNAL_RC_CLOCK [*2])
		else $error("failed source switched back");
	wake_rc_a: assert property (state == ST_FAILSAFE && !int_en[INT_FAIL] && idle_i && ext_int_i
		|=> cpu_wake_o && clk_sel_o == SEL_INTERNAL_RC_CLOCK)
		else $error("idle wake missing on internal rc");
	cfg_load_a: assert property (ld_vld && !$past(ld_vld) |=> cfg[$past(ld_idx)] == ($past(ld_word)
		| ~cfg_mask($past(ld_idx))))
		else $error("config word not loaded");
	lock_keep_a: assert property (por_n_i |=> (lock[2] & $past(lock[2])) == $past(lock[2]))
		else $error("write-once lock released");
endmodule

// ==== tb/ffc_partner.sv ====
`timescale 1ns/1ps
module ffc_partner
	import ffc_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [21:0] flash_addr_i,
	input wire logic flash_rd_i,
	input wire logic [1:0] mode_i,
	input wire logic prim_en_i,
	input wire logic osc_dead_i,
	output logic [15:0] flash_data_o,
	output logic prim_act_o,
	output logic sec_act_o
);
	logic vld;
	logic [15:0] word;
	logic [1:0] sec_cnt;
	logic [21:0] off;

	assign off = flash_addr_i - FLASH_CFG_ADDR;
	// flash word answers one cycle after the read strobe
	always_ff @(posedge clk_i) begin
		vld <= flash_rd_i;
		if (!nrst_i) begin
			word <= 16'h0000;
		end else if (flash_rd_i) begin
			case (off[2:1]) // byte addresses, two per word
				2'h0: word <= 16'hf5c3;
				2'h1: word <= {4'hf, 2'h3, mode_i, 8'hff};
				2'h2: word <= 16'hf0f0;
				default: word <= 16'h1234;
			endcase
		end
	end
	// outside the answer cycle the bus shows the inverse, never a stale copy
	assign flash_data_o = vld ? word : ~word;
	// primary ticks every other cycle while enabled and alive, secondary runs free
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			prim_act_o <= 1'b0;
			sec_cnt <= 2'h0;
			sec_act_o <= 1'b0;
		end else begin
			prim_act_o <= prim_en_i && !osc_dead_i && !prim_act_o;
			sec_cnt <= (sec_cnt == 2'h2) ? 2'h0 : sec_cnt + 2'h1;
			sec_act_o <= (sec_cnt == 2'h0);
		end
	end
endmodule

// ==== tb/test_failsafe_clock_and_config_load.sv ====
`timescale 1ns/1ps
module test_failsafe_clock_and_config_load
	import ffc_pkg::*;
;
	logic clk_i = 1'b0;
	logic nrst_i, por_n_i, reg_we_i, reg_re_i, cfg_re_i, pm_enter_i, sleep_i, wake_i, idle_i, ext_int_i;
	logic osc_dead, flash_rd_o, prim_act_i, sec_act_i, prim_en_o, pll_en_o, mon_active_o;
	logic cpu_wake_o, cfg_ready_o, irq_o;
	logic [7:0] reg_addr_i, cfg_rdata_o;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic [23:0] cfg_addr_i;
	logic [21:0] flash_addr_o;
	logic [15:0] flash_data_i;
	logic [1:0] mode, clk_sel_o;
	int n_fail = 0;
	int comparisons = 0;

	always #10 clk_i = ~clk_i;

	ffc_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .por_n_i(por_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.cfg_addr_i(cfg_addr_i), .cfg_re_i(cfg_re_i), .cfg_rdata_o(cfg_rdata_o), .flash_addr_o(flash_addr_o),
		.flash_rd_o(flash_rd_o), .flash_data_i(flash_data_i), .prim_act_i(prim_act_i), .sec_act_i(sec_act_i),
		.pm_enter_i(pm_enter_i), .sleep_i(sleep_i), .wake_i(wake_i), .idle_i(idle_i), .ext_int_i(ext_int_i),
		.prim_en_o(prim_en_o), .pll_en_o(pll_en_o), .clk_sel_o(clk_sel_o), .mon_active_o(mon_active_o),
		.cpu_wake_o(cpu_wake_o), .cfg_ready_o(cfg_ready_o), .irq_o(irq_o));

	ffc_partner far_side (.clk_i(clk_i), .nrst_i(nrst_i), .flash_addr_i(flash_addr_o), .flash_rd_i(flash_rd_o),
		.mode_i(mode), .prim_en_i(prim_en_o), .osc_dead_i(osc_dead), .flash_data_o(flash_data_i),
		.prim_act_o(prim_act_i), .sec_act_o(sec_act_i));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		#1;
	endtask

	// register read: data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask

	task automatic cchk(input logic [23:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		cfg_re_i <= 1'b1;
		cfg_addr_i <= a;
		@(posedge clk_i);
		cfg_re_i <= 1'b0;
		#1;
		chk({24'h0, cfg_rdata_o}, {24'h0, exp});
	endtask

	// pulse: 0 power-managed entry, 1 sleep, 2 wake
	task automatic pulse(input int k);
		@(posedge clk_i);
		case (k)
			0: pm_enter_i <= 1'b1;
			1: sleep_i <= 1'b1;
			default: wake_i <= 1'b1;
		endcase
		@(posedge clk_i);
		pm_enter_i <= 1'b0;
		sleep_i <= 1'b0;
		wake_i <= 1'b0;
		tick(1);
	endtask

	task automatic wait_sel(input logic [1:0] v, input int lim);
		for (int i = 0; i < lim && clk_sel_o !== v; i++) tick(1);
	endtask

	task automatic do_reset(input logic [1:0] m, input logic p);
		@(posedge clk_i);
		mode <= m;
		nrst_i <= 1'b0;
		por_n_i <= ~p;
		tick(5);
		chk({prim_en_o, clk_sel_o, mon_active_o, irq_o}, {1'b0, SEL_INTERNAL_RC_CLOCK, 2'b00});
		@(posedge clk_i);
		nrst_i <= 1'b1;
		por_n_i <= 1'b1;
		for (int i = 0; i < 40 && cfg_ready_o !== 1'b1; i++) tick(1);
	endtask

	// power-up load in crystal mode, config views, then two-speed start
	task automatic t_load_hs();
		do_reset(OSC_HS, 1'b1);
		chk(cfg_ready_o, 1'b1);
		rchk(REG_CFG_BASE, 32'h0000f5c3);
		rchk(REG_CFG_BASE + 8'h04, {16'h0, 4'hf, 2'h3, OSC_HS, 8'hff});
		rchk(REG_CFG_BASE + 8'h08, 32'h0000f0f0);
		rchk(REG_CFG_BASE + 8'h0c, 32'h00001234);
		cchk(CFG_SPACE_BASE, 8'hc3);
		cchk(CFG_SPACE_BASE + 24'h1, 8'hf5);
		cchk(CFG_SPACE_BASE + 24'h7, 8'h12);
		cchk(CFG_SPACE_BASE + 24'h8, 8'h00);
		rchk(8'h20, 32'h0);
		chk({prim_en_o, clk_sel_o, mon_active_o}, {1'b1, SEL_INTERNAL_RC_CLOCK, 1'b0});
		rchk(REG_OSC_CTRL, 32'h0);
		// word 2 takes one write only; top nibble always reads ones
		wr(REG_CFG_BASE + 8'h08, 32'h00000abc);
		rchk(REG_CFG_BASE + 8'h08, 32'h0000fabc);
		wr(REG_CFG_BASE + 8'h08, 32'h0000ffff);
		rchk(REG_CFG_BASE + 8'h08, 32'h0000fabc);
		tick(1900);
		chk(clk_sel_o, SEL_INTERNAL_RC_CLOCK);
		wait_sel(SEL_PRIMARY, 400);
		chk({clk_sel_o, mon_active_o, pll_en_o}, {SEL_PRIMARY, 2'b10});
		rchk(REG_OSC_CTRL, 32'h8);
		rchk(REG_STATUS, 32'h6);
		chk(irq_o, 1'b0);
	endtask

	// failure in run mode, fail-safe exits, failure in power-managed mode
	task automatic t_fail();
		wr(REG_INT_EN, 32'h7);
		tick(1);
		chk(irq_o, 1'b1);
		wr(REG_INT_CLR, 32'h7);
		tick(1);
		chk(irq_o, 1'b0);
		@(posedge clk_i);
		osc_dead <= 1'b1;
		wait_sel(SEL_INTERNAL_RC_CLOCK, 40);
		chk({clk_sel_o, prim_en_o}, {SEL_INTERNAL_RC_CLOCK, 1'b0});
		tick(1);
		chk(irq_o, 1'b1);
		rchk(REG_STATUS, 32'h1);
		rchk(REG_OSC_CTRL, 32'h4);
		@(posedge clk_i);
		osc_dead <= 1'b0;
		tick(200);
		chk(clk_sel_o, SEL_INTERNAL_RC_CLOCK);
		wr(REG_INT_EN, 32'h6);
		@(posedge clk_i);
		idle_i <= 1'b1;
		ext_int_i <= 1'b1;
		tick(2);
		chk(cpu_wake_o, 1'b1);
		@(posedge clk_i);
		idle_i <= 1'b0;
		ext_int_i <= 1'b0;
		pulse(0);
		chk({clk_sel_o, mon_active_o}, {SEL_PRIMARY, 1'b1});
		wr(REG_INT_EN, 32'h7);
		@(posedge clk_i);
		osc_dead <= 1'b1;
		wait_sel(SEL_INTERNAL_RC_CLOCK, 40);
		chk(clk_sel_o, SEL_INTERNAL_RC_CLOCK);
		@(posedge clk_i);
		osc_dead <= 1'b0;
		tick(100);
		chk(clk_sel_o, SEL_INTERNAL_RC_CLOCK);
		wr(REG_OSC_CTRL, {30'h0, SEL_SECONDARY});
		pulse(0);
		chk({clk_sel_o, mon_active_o}, {SEL_SECONDARY, 1'b1});
		wr(REG_OSC_CTRL, {30'h0, SEL_INTERNAL_RC_CLOCK});
		pulse(0);
		chk({clk_sel_o, mon_active_o}, {SEL_INTERNAL_RC_CLOCK, 1'b0});
	endtask

	// multiplier mode: PLL wait after the start-up timer; locks survive reset
	task automatic t_pll();
		do_reset(OSC_CRYSTAL_WITH_MULTIPLIER_MODE, 1'b0);
		rchk(REG_CFG_BASE + 8'h08, 32'h0000f0f0);
		wr(REG_CFG_BASE + 8'h08, 32'h0);
		rchk(REG_CFG_BASE + 8'h08, 32'h0000f0f0);
		tick(2090);
		chk({pll_en_o, clk_sel_o}, {1'b1, SEL_INTERNAL_RC_CLOCK});
		wait_sel(SEL_PRIMARY, 300);
		chk({pll_en_o, clk_sel_o}, {1'b1, SEL_PRIMARY});
	endtask

	// primary never starts: no failure, then power-managed entry drops it
	task automatic t_dead();
		osc_dead = 1'b1;
		do_reset(OSC_HS, 1'b0);
		tick(2300);
		chk(clk_sel_o, SEL_INTERNAL_RC_CLOCK);
		rchk(REG_STATUS, 32'h4);
		rchk(REG_OSC_CTRL, 32'h0);
		wr(REG_OSC_CTRL, {30'h0, SEL_SECONDARY});
		pulse(0);
		chk({prim_en_o, clk_sel_o}, {1'b0, SEL_SECONDARY});
		osc_dead = 1'b0;
	endtask

	// external clock: monitored at once, again after sleep and wake
	task automatic t_ext();
		do_reset(OSC_EXT, 1'b0);
		wait_sel(SEL_PRIMARY, 5);
		chk({clk_sel_o, mon_active_o}, {SEL_PRIMARY, 1'b1});
		pulse(1);
		chk({prim_en_o, clk_sel_o, mon_active_o}, {1'b0, SEL_INTERNAL_RC_CLOCK, 1'b0});
		pulse(2);
		wait_sel(SEL_PRIMARY, 5);
		chk({clk_sel_o, mon_active_o}, {SEL_PRIMARY, 1'b1});
		// internal rc mode: also monitored at once after load
		do_reset(OSC_INTERNAL_RC_CLOCK, 1'b0);
		wait_sel(SEL_PRIMARY, 5);
		chk({clk_sel_o, mon_active_o, prim_en_o}, {SEL_PRIMARY, 2'b11});
	endtask

	initial begin
		nrst_i = 1'b0;
		por_n_i = 1'b0;
		{reg_we_i, reg_re_i, cfg_re_i, pm_enter_i, sleep_i, wake_i, idle_i, ext_int_i, osc_dead} = '0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		cfg_addr_i = 24'h0;
		mode = OSC_HS;
		t_load_hs();
		t_fail();
		t_pll();
		t_dead();
		t_ext();
		report_and_stop();
	end

	// watchdog well beyond the expected seven thousand cycles
	initial begin
		#400000;
		n_fail++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule
